// File: cpp_pkg.sv
// Constants shared by the colour palette pixel path.
package cpp_pkg;
    // Pixel group layout.
    localparam int CPP_PIXELS      = 5;
    localparam int CPP_PLANES      = 8;
    localparam int CPP_PIX_W       = 12;
    localparam int CPP_GROUP_W     = CPP_PIXELS * CPP_PIX_W;
    localparam int CPP_POS_OVL     = 8;
    localparam int CPP_POS_SYNC    = 10;
    localparam int CPP_POS_BLANK   = 11;
    localparam logic [2:0] CPP_LAST_SLOT_4 = 3'h3;
    localparam logic [2:0] CPP_LAST_SLOT_5 = 3'h4;
    localparam int CPP_FIFO_DEPTH  = 16;
    // Index pointer values of the last overlay entry and the control registers.
    localparam logic [7:0] CPP_IDX_OVL_LAST   = 8'h03;
    localparam logic [7:0] CPP_IDX_READ_MASK  = 8'h04;
    localparam logic [7:0] CPP_IDX_BLINK_MASK = 8'h05;
    localparam logic [7:0] CPP_IDX_COMMAND    = 8'h06;
    localparam logic [7:0] CPP_IDX_TEST       = 8'h07;
    // Port select codes, written as {port_select_1, port_select_0}.
    localparam logic [1:0] CPP_SEL_INDEX   = 2'h0;
    localparam logic [1:0] CPP_SEL_PALETTE = 2'h1;
    localparam logic [1:0] CPP_SEL_CONTROL = 2'h2;
    localparam logic [1:0] CPP_SEL_OVERLAY = 2'h3;
    // Colour phase counter values; colour words are {red, green, blue}.
    localparam logic [1:0] CPP_PHASE_RED   = 2'h0;
    localparam logic [1:0] CPP_PHASE_GREEN = 2'h1;
    localparam logic [1:0] CPP_PHASE_BLUE  = 2'h2;
    // Display command bit positions.
    localparam int CPP_CMD_MUX      = 7;
    localparam int CPP_CMD_RAM_EN   = 6;
    localparam int CPP_CMD_RATE_LO  = 4;
    localparam int CPP_CMD_OL1_BLK  = 3;
    localparam int CPP_CMD_OL0_BLK  = 2;
    localparam int CPP_CMD_OL1_EN   = 1;
    localparam int CPP_CMD_OL0_EN   = 0;
    // Converter input probe bits.
    localparam int CPP_TST_RED      = 0;
    localparam int CPP_TST_GREEN    = 1;
    localparam int CPP_TST_BLUE     = 2;
    localparam int CPP_TST_MSB      = 3;
    // Blink timing in vertical periods, indexed by the rate field.
    localparam logic [7:0] CPP_BLINK_ON_0  = 8'h10;
    localparam logic [7:0] CPP_BLINK_PER_0 = 8'h40;
    localparam logic [7:0] CPP_BLINK_ON_1  = 8'h10;
    localparam logic [7:0] CPP_BLINK_PER_1 = 8'h20;
    localparam logic [7:0] CPP_BLINK_ON_2  = 8'h20;
    localparam logic [7:0] CPP_BLINK_PER_2 = 8'h40;
    localparam logic [7:0] CPP_BLINK_ON_3  = 8'h40;
    localparam logic [7:0] CPP_BLINK_PER_3 = 8'h80;
    // Strobe cycles of low blank that mark a vertical retrace.
    localparam logic [8:0] CPP_RETRACE_CYCLES = 9'h100;
endpackage

// File: color_palette_pixel_path.sv
// Palette pixel path: group FIFO and the palette core top module.
`timescale 1ns/1ps

module cpp_group_fifo #(
    parameter int WIDTH = 60,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,      // Pixel clock.
    input  wire logic             rst_n,    // Synchronous reset, active low.
    input  wire logic             ce,       // Clock enable.
    input  wire logic             inValid,  // Write request.
    output logic                  inReady,  // Space available.
    input  wire logic [WIDTH-1:0] inData,   // Write data.
    output logic                  outValid, // Data available.
    input  wire logic             outReady, // Read request.
    output logic      [WIDTH-1:0] outData   // Head of queue.
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0]   FULL_COUNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [PW:0]      count_q;
    wire              doWrite = inValid & inReady;
    wire              doRead  = outValid & outReady;

    // Full and empty come from the count, so both stay exact.
    assign inReady  = (count_q != FULL_COUNT);
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];

    // Storage needs no reset; only the pointers and count carry control state.
    always_ff @(posedge clk) begin
        if (ce && doWrite) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers wrap by compare so any depth works.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (ce) begin
            if (doWrite) begin
                wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
            end
            if (doRead) begin
                rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (PW+1)'(doWrite) - (PW+1)'(doRead);
        end
    end
endmodule

module color_palette_pixel_path #(
    parameter int FIFO_DEPTH = cpp_pkg::CPP_FIFO_DEPTH
) (
    input  wire logic        clk,             // Pixel clock, 100 MHz.
    input  wire logic        rst_n,           // Synchronous reset.
    input  wire logic        ce,              // Clock enable.
    input  wire logic        pixelLoadStrobe, // Load strobe pin.
    input  wire logic [39:0] planeBits,       // Five 8-bit indices.
    input  wire logic [4:0]  overlaySelect0,  // Overlay select 0 per pixel.
    input  wire logic [4:0]  overlaySelect1,  // Overlay select 1 per pixel.
    input  wire logic [4:0]  syncInputN,      // Sync per pixel, low.
    input  wire logic [4:0]  blankInputN,     // Blank per pixel, low.
    input  wire logic        hostEnableN,     // Host chip enable, low.
    input  wire logic        readNotWrite,    // Host direction.
    input  wire logic        portSelect0,     // Host port select 0.
    input  wire logic        portSelect1,     // Host port select 1.
    input  wire logic [7:0]  hostDataIn,      // Host data pins in.
    output logic      [7:0]  hostDataOut,     // Host data pins out.
    output logic             hostDataOe,      // Host data drive enable.
    output logic      [7:0]  redOut,          // Red converter input.
    output logic      [7:0]  greenOut,        // Green converter input.
    output logic      [7:0]  blueOut,         // Blue converter input.
    output logic             greenSyncN,      // Sync to green only.
    output logic             blankOutN        // Blank to converters.
);
    import cpp_pkg::*;

    // Pick one 8-bit component of a colour word by phase.
    function automatic logic [7:0] pickComp(input logic [23:0] w,
                                            input logic [1:0] ph);
        unique case (ph)
            CPP_PHASE_RED:   pickComp = w[23:16];
            CPP_PHASE_GREEN: pickComp = w[15:8];
            default:         pickComp = w[7:0];
        endcase
    endfunction

    logic [23:0]            palette [0:255];
    logic [23:0]            overlay [0:3];
    logic [7:0]             index_q;
    logic [1:0]             phase_q;
    logic [7:0]             redHold_q;
    logic [7:0]             greenHold_q;
    logic [7:0]             readMask_q;
    logic [7:0]             blinkMask_q;
    logic [7:0]             command_q;
    logic [3:0]             testLow_q;
    logic [2:0]             loadSync_q;
    logic                   loadState_q;
    logic [3:0]             hs1_q;
    logic [3:0]             hs2_q;
    logic [3:0]             hs3_q;
    logic [3:0]             hostState_q;
    logic [1:0]             accSel_q;
    logic                   accRead_q;
    logic [8:0]             blankCount_q;
    logic [7:0]             blinkPhase_q;
    logic                   blinkOn_q;
    logic [CPP_GROUP_W-1:0] group_q;
    logic [2:0]             slot_q;
    logic                   running_q;

    // Strobe edge: counted only once the second and third stages agree.
    wire loadRise = loadSync_q[1] & loadSync_q[2] & ~loadState_q;

    // Host pin state with the same agreement filter; bit 0 is enable.
    wire [3:0] hsDiff     = hs2_q ^ hs3_q;
    wire [3:0] hostStateD = (hs2_q & ~hsDiff) | (hostState_q & hsDiff);
    wire       accStart   = hostState_q[0] & ~hostStateD[0];
    wire       accEnd     = ~hostState_q[0] & hostStateD[0];
    wire       accWrite   = accEnd & ~accRead_q;

    // Command fields.
    wire       mux5      = command_q[CPP_CMD_MUX];
    wire       ramEnable = command_q[CPP_CMD_RAM_EN];
    wire [1:0] rateField = command_q[CPP_CMD_RATE_LO +: 2];
    wire [7:0] blinkOnLen = (rateField == 2'h0) ? CPP_BLINK_ON_0 :
                            (rateField == 2'h1) ? CPP_BLINK_ON_1 :
                            (rateField == 2'h2) ? CPP_BLINK_ON_2 :
                                                  CPP_BLINK_ON_3;
    wire [7:0] blinkPer  = (rateField == 2'h0) ? CPP_BLINK_PER_0 :
                           (rateField == 2'h1) ? CPP_BLINK_PER_1 :
                           (rateField == 2'h2) ? CPP_BLINK_PER_2 :
                                                 CPP_BLINK_PER_3;

    // Overlay gating before capture: display enable, then blink.
    wire ol0Pass = command_q[CPP_CMD_OL0_EN] &
                   (~command_q[CPP_CMD_OL0_BLK] | blinkOn_q);
    wire ol1Pass = command_q[CPP_CMD_OL1_EN] &
                   (~command_q[CPP_CMD_OL1_BLK] | blinkOn_q);

    // Pack each pixel; the fifth index and overlay are dropped in 4:1.
    logic [CPP_GROUP_W-1:0] captured;
    for (genvar p = 0; p < CPP_PIXELS; p++) begin : g_pix
        wire pixOn = (p < CPP_PIXELS - 1) | mux5;
        assign captured[p*CPP_PIX_W +: CPP_PIX_W] = {
            blankInputN[p],
            syncInputN[p],
            overlaySelect1[p] & ol1Pass & pixOn,
            overlaySelect0[p] & ol0Pass & pixOn,
            planeBits[p*CPP_PLANES +: CPP_PLANES] & {CPP_PLANES{pixOn}}
        };
    end

    // Group queue between capture and the output latches.
    wire                   fifoInReady;
    wire                   fifoOutValid;
    wire [CPP_GROUP_W-1:0] fifoOutData;
    wire [2:0]             lastSlot = mux5 ? CPP_LAST_SLOT_5 : CPP_LAST_SLOT_4;
    wire                   slotFree = ~running_q | (slot_q == lastSlot);
    wire                   loadPulse = fifoOutValid & slotFree;

    cpp_group_fifo #(
        .WIDTH (CPP_GROUP_W),
        .DEPTH (FIFO_DEPTH)
    ) i_cpp_group_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .inValid  (loadRise),
        .inReady  (fifoInReady),
        .inData   (captured),
        .outValid (fifoOutValid),
        .outReady (slotFree),
        .outData  (fifoOutData)
    );

    // Current pixel and its colour selection.
    wire [CPP_PIX_W-1:0] curPix  = group_q[slot_q*CPP_PIX_W +: CPP_PIX_W];
    wire [7:0]  planeOff = blinkOn_q ? 8'hFF : ~blinkMask_q;
    wire [7:0]  planeIdx = curPix[7:0] & readMask_q & planeOff;
    wire [1:0]  ovlSel   = curPix[CPP_POS_OVL +: 2];
    wire        usePal   = ramEnable & (ovlSel == 2'h0);
    wire [23:0] colour   = usePal ? palette[planeIdx] : overlay[ovlSel];
    wire        pixBlank = ~running_q | ~curPix[CPP_POS_BLANK];

    // Host address validity per access type.
    wire isCtrl = (index_q >= CPP_IDX_READ_MASK) & (index_q <= CPP_IDX_TEST);
    wire isOvl  = (index_q <= CPP_IDX_OVL_LAST);
    wire wrPal  = accWrite & (accSel_q == CPP_SEL_PALETTE);
    wire wrOvl  = accWrite & (accSel_q == CPP_SEL_OVERLAY) & isOvl;
    wire wrCtl  = accWrite & (accSel_q == CPP_SEL_CONTROL) & isCtrl;
    wire wrIdx  = accWrite & (accSel_q == CPP_SEL_INDEX);
    wire isBlue = (phase_q == CPP_PHASE_BLUE);
    wire [23:0] hostWord = {redHold_q, greenHold_q, hostDataIn};

    // Probe nibble of the live converter inputs.
    wire [7:0] probeSrc = testLow_q[CPP_TST_BLUE]  ? blueOut  :
                          testLow_q[CPP_TST_GREEN] ? greenOut : redOut;
    wire [3:0] probeNib = testLow_q[CPP_TST_MSB] ? probeSrc[7:4]
                                                 : probeSrc[3:0];

    // Read data by port select and index; invalid indices read zero.
    wire [1:0] startSel = {hostStateD[3], hostStateD[2]};
    wire [7:0] ctlRead =
        (index_q == CPP_IDX_READ_MASK)  ? readMask_q  :
        (index_q == CPP_IDX_BLINK_MASK) ? blinkMask_q :
        (index_q == CPP_IDX_COMMAND)    ? command_q   :
        (index_q == CPP_IDX_TEST)       ? {probeNib, testLow_q} : 8'h00;
    wire [7:0] readData =
        (startSel == CPP_SEL_INDEX)   ? index_q :
        (startSel == CPP_SEL_PALETTE) ? pickComp(palette[index_q], phase_q) :
        (startSel == CPP_SEL_OVERLAY) ?
            (isOvl ? pickComp(overlay[index_q[1:0]], phase_q) : 8'h00) :
        ctlRead;

    // Input synchronisers for strobe and host control pins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loadSync_q  <= '0;
            loadState_q <= 1'b0;
            hs1_q       <= 4'hF;
            hs2_q       <= 4'hF;
            hs3_q       <= 4'hF;
            hostState_q <= 4'hF;
        end else if (ce) begin
            loadSync_q <= {loadSync_q[1:0], pixelLoadStrobe};
            if (loadSync_q[1] == loadSync_q[2]) begin
                loadState_q <= loadSync_q[2];
            end
            hs1_q       <= {portSelect1, portSelect0, readNotWrite, hostEnableN};
            hs2_q       <= hs1_q;
            hs3_q       <= hs2_q;
            hostState_q <= hostStateD;
        end
    end

    // Colour memories: a separate display read port lets host writes
    // land during refresh; a blue write to the entry on screen can
    // disturb only the pixel shown in that clock.
    always_ff @(posedge clk) begin
        if (ce && wrPal && isBlue) begin
            palette[index_q] <= hostWord;
        end
        if (ce && wrOvl && isBlue) begin
            overlay[index_q[1:0]] <= hostWord;
        end
    end

    // Host access sequencing, index pointer and colour phase counter.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            index_q     <= 8'h00;
            phase_q     <= CPP_PHASE_RED;
            redHold_q   <= 8'h00;
            greenHold_q <= 8'h00;
            accSel_q    <= CPP_SEL_INDEX;
            accRead_q   <= 1'b0;
            hostDataOut <= 8'h00;
            hostDataOe  <= 1'b0;
        end else if (ce) begin
            if (accStart) begin
                accSel_q    <= startSel;
                accRead_q   <= hostStateD[1];
                hostDataOut <= readData;
                hostDataOe  <= hostStateD[1];
            end
            if (accEnd) begin
                hostDataOe <= 1'b0;
                if (accSel_q == CPP_SEL_INDEX) begin
                    phase_q <= CPP_PHASE_RED;
                end else if (accSel_q != CPP_SEL_CONTROL &&
                             (accSel_q == CPP_SEL_PALETTE || isOvl)) begin
                    phase_q <= isBlue ? CPP_PHASE_RED : phase_q + 2'h1;
                    if (isBlue) begin
                        index_q <= index_q + 8'h01;
                    end
                end
            end
            if (wrIdx) begin
                index_q <= hostDataIn;
            end
            if ((wrPal || wrOvl) && phase_q == CPP_PHASE_RED) begin
                redHold_q <= hostDataIn;
            end
            if ((wrPal || wrOvl) && phase_q == CPP_PHASE_GREEN) begin
                greenHold_q <= hostDataIn;
            end
        end
    end

    // Control registers; reset clears them only to give defined state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readMask_q  <= 8'h00;
            blinkMask_q <= 8'h00;
            command_q   <= 8'h00;
            testLow_q   <= 4'h0;
        end else if (ce && wrCtl) begin
            if (index_q == CPP_IDX_READ_MASK) begin
                readMask_q <= hostDataIn;
            end
            if (index_q == CPP_IDX_BLINK_MASK) begin
                blinkMask_q <= hostDataIn;
            end
            if (index_q == CPP_IDX_COMMAND) begin
                command_q <= hostDataIn;
            end
            if (index_q == CPP_IDX_TEST) begin
                testLow_q <= hostDataIn[3:0];
            end
        end
    end

    // Retrace detect and blink phase; blink state moves only here.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blankCount_q <= 9'h000;
            blinkPhase_q <= 8'h00;
            blinkOn_q    <= 1'b1;
        end else if (ce && loadRise) begin
            if (|blankInputN) begin
                blankCount_q <= 9'h000;
            end else if (blankCount_q != CPP_RETRACE_CYCLES) begin
                blankCount_q <= blankCount_q + 9'h001;
            end
            if (~|blankInputN &&
                blankCount_q == CPP_RETRACE_CYCLES - 9'h001) begin
                if (blinkPhase_q + 8'h01 >= blinkPer) begin
                    blinkPhase_q <= 8'h00;
                    blinkOn_q    <= 1'b1;
                end else begin
                    blinkPhase_q <= blinkPhase_q + 8'h01;
                    blinkOn_q    <= (blinkPhase_q + 8'h01) < blinkOnLen;
                end
            end
        end
    end

    // Output latches: loaded by the internal pulse, stepped per clock.
    // A missing group blanks the screen rather than repeating stale data.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            group_q   <= '0;
            slot_q    <= 3'h0;
            running_q <= 1'b0;
        end else if (ce) begin
            if (loadPulse) begin
                group_q   <= fifoOutData;
                slot_q    <= 3'h0;
                running_q <= 1'b1;
            end else if (slotFree) begin
                running_q <= 1'b0;
            end else begin
                slot_q <= slot_q + 3'h1;
            end
        end
    end

    // Converter drive, one pixel per clock.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            redOut     <= 8'h00;
            greenOut   <= 8'h00;
            blueOut    <= 8'h00;
            greenSyncN <= 1'b1;
            blankOutN  <= 1'b0;
        end else if (ce) begin
            redOut     <= pixBlank ? 8'h00 : colour[23:16];
            greenOut   <= pixBlank ? 8'h00 : colour[15:8];
            blueOut    <= pixBlank ? 8'h00 : colour[7:0];
            greenSyncN <= ~running_q | curPix[CPP_POS_SYNC];
            blankOutN  <= ~pixBlank;
        end
    end

    // The strobe period is the far side's duty; an early group only
    // waits in the queue, and a full queue drops further captures.
    wire unusedReady = fifoInReady;
endmodule

// File: cpp_path_properties.sv
// Port-level assertions for the palette pixel path.
`timescale 1ns/1ps

module cpp_path_properties #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic       clk,             // Pixel clock.
    input wire logic       rst_n,           // Synchronous reset.
    input wire logic       ce,              // Clock enable.
    input wire logic       pixelLoadStrobe, // Load strobe pin.
    input wire logic       hostEnableN,     // Host chip enable, low.
    input wire logic       readNotWrite,    // Host direction.
    input wire logic [7:0] hostDataOut,     // Host read data.
    input wire logic       hostDataOe,      // Host data drive enable.
    input wire logic [7:0] redOut,          // Red converter input.
    input wire logic [7:0] greenOut,        // Green converter input.
    input wire logic [7:0] blueOut,         // Blue converter input.
    input wire logic       blankOutN        // Blank to converters.
);
    localparam int IDLE_LIMIT = FIFO_DEPTH * 5 + 40;
    int idleCnt_q;
    // A full queue drains in at most five clocks a group, so past this the path is dry.
    always_ff @(posedge clk) begin
        if (!rst_n || pixelLoadStrobe) begin
            idleCnt_q <= 0;
        end else if (ce && idleCnt_q < IDLE_LIMIT) begin
            idleCnt_q <= idleCnt_q + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_blank_black: assert property (
        !blankOutN |-> {redOut, greenOut, blueOut} == 24'h0)
        else $error("colour present while blanked");
    a_read_answer: assert property (
        $fell(hostEnableN) && readNotWrite |-> ##[2:6] hostDataOe)
        else $error("read not answered");
    a_read_cause: assert property (
        $rose(hostDataOe) |-> $past(readNotWrite, 2) && !$past(hostEnableN, 2))
        else $error("data driven without a read");
    a_read_stands: assert property (
        hostDataOe && $past(hostDataOe) |-> $stable(hostDataOut))
        else $error("read data changed while driven");
    a_write_quiet: assert property (
        $fell(hostEnableN) && !readNotWrite |=> !hostDataOe [*6])
        else $error("data driven during a write");
    a_oe_release: assert property (
        hostEnableN [*7] |-> !hostDataOe)
        else $error("data still driven after release");
    a_idle_blank: assert property (
        idleCnt_q == IDLE_LIMIT |-> !blankOutN)
        else $error("pixels shown without a loaded group");
    a_hold_frozen: assert property (
        !ce |=> $stable({redOut, greenOut, blueOut, blankOutN}))
        else $error("outputs moved while clock disabled");
endmodule

bind color_palette_pixel_path cpp_path_properties #(
    .FIFO_DEPTH(FIFO_DEPTH)
) i_cpp_path_properties (.clk, .rst_n, .ce, .pixelLoadStrobe, .hostEnableN,
    .readNotWrite, .hostDataOut, .hostDataOe, .redOut, .greenOut, .blueOut,
    .blankOutN);

// File: cpp_frame_source.sv
// Frame buffer model: one strobe and pixel group every four or five clocks.
`timescale 1ns/1ps

module cpp_frame_source (
    input  wire logic        clk,    // Pixel clock.
    input  wire logic        five,   // Five pixels a group.
    input  wire logic        run,    // Strobe running.
    input  wire logic        vis,    // Pixels not blanked.
    input  wire logic [7:0]  index,  // Index sent for each pixel.
    output logic             strobe, // Load strobe.
    output logic      [39:0] planes, // Plane bits.
    output logic      [4:0]  blankN  // Blank per pixel, low.
);
    logic [2:0] cnt = 3'h0;
    // The strobe rises once a period; data is steady long before it rises.
    always @(posedge clk) begin
        #1;
        cnt = (cnt >= (five ? 3'h4 : 3'h3)) ? 3'h0 : cnt + 3'h1;
        strobe = run && (cnt >= 3'h2);
        planes = {(five ? index : 8'h00), {4{index}}};
        blankN = {5{vis}};
    end
endmodule

// File: color_palette_pixel_path_tb.sv
// Self-checking bench of the palette pixel path.
`timescale 1ns/1ps

module color_palette_pixel_path_tb;
    import cpp_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, enN = 1'b1, rnw = 1'b1;
    logic        five = 1'b0, run = 1'b1, vis = 1'b1, strobe, oe, gsN, bN;
    logic [1:0]  sel = 2'h0;
    logic [4:0]  ol0 = 5'h00, sy = 5'h1F;
    logic [7:0]  din = 8'h00, rd, dout, r, g, b, hostBus;
    logic [39:0] planes;
    logic [4:0]  blankN;
    int          num_errors = 0, checked = 0;
    // The shared data pins carry the design's byte only while it drives.
    assign hostBus = oe ? dout : din;
    cpp_frame_source i_cpp_frame_source (.clk(clk), .five(five), .run(run),
        .vis(vis), .index(8'h01), .strobe(strobe), .planes(planes),
        .blankN(blankN));
    color_palette_pixel_path i_color_palette_pixel_path (.clk(clk),
        .rst_n(rst_n), .ce(ce), .pixelLoadStrobe(strobe), .planeBits(planes),
        .overlaySelect0(ol0), .overlaySelect1(5'h00), .syncInputN(sy),
        .blankInputN(blankN), .hostEnableN(enN), .readNotWrite(rnw),
        .portSelect0(sel[0]), .portSelect1(sel[1]), .hostDataIn(hostBus),
        .hostDataOut(dout), .hostDataOe(oe), .redOut(r), .greenOut(g),
        .blueOut(b), .greenSyncN(gsN), .blankOutN(bN));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    // Enable is held six clocks each way, well past the pin synchroniser.
    task automatic host(input logic w, input logic [1:0] s,
                        input logic [7:0] d);
        @(posedge clk);
        #1 {rnw, sel, din, enN} = {~w, s, d, 1'b0};
        repeat (6) @(posedge clk);
        rd = dout;
        if (!w) check({23'h0, oe}, 24'h1);
        #1 enN = 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic look(input logic [23:0] exp, input logic v);
        repeat (120) @(posedge clk);
        repeat (8) begin
            @(posedge clk);
            #1 check({r, g, b}, exp);
            check({23'h0, bN}, {23'h0, v});
        end
    endtask
    task automatic test_registers;
        for (int i = 4; i < 7; i++) begin
            host(1'b1, CPP_SEL_INDEX, 8'(i));
            host(1'b1, CPP_SEL_CONTROL, 8'hA0 + 8'(i));
            host(1'b0, CPP_SEL_CONTROL, 8'h00);
            check({16'h0, rd}, 24'hA0 + 24'(i));
            host(1'b0, CPP_SEL_INDEX, 8'h00);
            check({16'h0, rd}, 24'(i));
        end
        host(1'b1, CPP_SEL_INDEX, 8'h08);
        host(1'b1, CPP_SEL_CONTROL, 8'h5A);
        host(1'b0, CPP_SEL_CONTROL, 8'h00);
        check({16'h0, rd}, 24'h0);
        host(1'b1, CPP_SEL_INDEX, CPP_IDX_COMMAND);
        host(1'b0, CPP_SEL_CONTROL, 8'h00);
        check({16'h0, rd}, 24'hA6);
        $display("test registers done");
    endtask
    task automatic test_colours;
        host(1'b1, CPP_SEL_INDEX, 8'h00);
        for (int i = 1; i < 7; i++) host(1'b1, CPP_SEL_OVERLAY, 8'(i * 8'h11));
        host(1'b1, CPP_SEL_INDEX, 8'h00);
        for (int i = 4; i < 10; i++) host(1'b1, CPP_SEL_PALETTE, 8'(i * 8'h11));
        host(1'b0, CPP_SEL_INDEX, 8'h00);
        check({16'h0, rd}, 24'h2);
        host(1'b1, CPP_SEL_INDEX, CPP_IDX_READ_MASK);
        host(1'b1, CPP_SEL_CONTROL, 8'hFF);
        #1 ol0 = 5'h1F;
        host(1'b1, CPP_SEL_INDEX, CPP_IDX_COMMAND);
        host(1'b1, CPP_SEL_CONTROL, 8'h40);
        look(24'h778899, 1'b1);
        host(1'b1, CPP_SEL_INDEX, CPP_IDX_TEST);
        host(1'b1, CPP_SEL_CONTROL, 8'h0C);
        host(1'b0, CPP_SEL_CONTROL, 8'h00);
        check({16'h0, rd}, 24'h9C);
        host(1'b1, CPP_SEL_INDEX, CPP_IDX_COMMAND);
        host(1'b1, CPP_SEL_CONTROL, 8'h41);
        look(24'h445566, 1'b1);
        ol0 = 5'h00;
        host(1'b1, CPP_SEL_CONTROL, 8'h00);
        look(24'h112233, 1'b1);
        host(1'b1, CPP_SEL_CONTROL, 8'hC0);
        five = 1'b1;
        look(24'h778899, 1'b1);
        host(1'b1, CPP_SEL_INDEX, CPP_IDX_READ_MASK);
        host(1'b1, CPP_SEL_CONTROL, 8'h00);
        look(24'h445566, 1'b1);
        $display("test colours done");
    endtask
    task automatic test_blank_idle;
        {vis, sy} = {1'b0, 5'h00};
        look(24'h0, 1'b0);
        check({23'h0, gsN}, 24'h0);
        {vis, sy} = {1'b1, 5'h1F};
        run = 1'b0;
        look(24'h0, 1'b0);
        #1 ce = 1'b0;
        repeat (4) @(posedge clk);
        #1 ce = 1'b1;
        $display("test blank idle done");
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        num_errors++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        test_registers();
        test_colours();
        test_blank_idle();
        conclude();
    end
endmodule
